// File: shared/eebf_defs.vh
// Purpose: constants of the two-wire memory bus front end
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef EEBF_DEFS_VH
`define EEBF_DEFS_VH
`define EEBF_CLK_MHZ 50
`define EEBF_TWR_US 5000
`define EEBF_TWR_CYC (`EEBF_TWR_US * `EEBF_CLK_MHZ)
`define EEBF_DEV_CODE 4'h5
`define EEBF_BYTE_BITS 8
`define EEBF_ERASED 8'hFF
`define EEBF_BUF_DEPTH 2
`endif

// File: hdl/eebf_buf2.v
// Purpose: two-entry skid buffer with valid/ready on both sides
// Assumes: single clock, synchronous reset
// Notes: full and empty are exact; no word lost on a stall
`timescale 1ns/1ns
`default_nettype none
module eebf_buf2 #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // fill side
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    // drain side
    output wire o_valid,
    input wire i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem_q [0:1]; // two entries
    reg wp_q; // write pointer
    reg rp_q; // read pointer
    reg [1:0] cnt_q; // occupancy
    wire push = i_valid && (cnt_q != 2'd2);
    wire pop = (cnt_q != 2'd0) && i_ready;
    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rp_q];
    ////////////////////////////////////////////////////////////////////////////
    // pointer and occupancy update
    always @(posedge i_clk) begin
        if (i_srst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= i_data;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end
endmodule // eebf_buf2
`default_nettype wire

// File: hdl/eebf_top.v
// Purpose: bus-side front end of a two-wire serial memory
// Assumes: SCL and SDA are asynchronous, sampled at 50 MHz
// Notes: memory array lives outside; bytes leave through a 2-entry buffer
// Function
// RULE_01: SDA fall with SCL high is start
// RULE_02: master opens each transaction with start
// RULE_03: SDA rise with SCL high is stop
// RULE_04: stop during read returns to standby
// RULE_05: stop during write starts write cycle; code starts it only after a data byte and with write protect off
// RULE_06: data changes only while SCL low
// RULE_07: SDA change in SCL high never data
// RULE_08: three straps give eight addresses
// RULE_09: answer only when strap bits match
// RULE_10: straps pulled down, open reads zero
// RULE_11: SDA open drain, only drives low
// RULE_12: work on SCL rising or falling edges
// RULE_13: WP high protects, low/open does not
// RULE_14: erased memory reads all ones
// RULE_15: sample on rise, drive after fall
// RULE_16: byte of eight, ninth clock acknowledges
// RULE_17: master sends code, strap bits, R/W
// RULE_18: no acknowledge during internal write cycle
// RULE_19: protected writes blocked, data not acknowledged
`timescale 1ns/1ns
`default_nettype none
`include "eebf_defs.vh"
module eebf_top #(
    parameter TWR_CYC = `EEBF_TWR_CYC,
    parameter [7:0] ERASED = `EEBF_ERASED
) (
    // clock and reset
    input wire I_CLK,
    input wire I_SRST,
    // two-wire bus pins
    input wire I_SCL,
    input wire I_SDA,
    output reg O_SDA,
    output reg O_SDA_OE,
    // straps and write protect (pull-downs outside make open read 0)
    input wire I_ADDR_STRAP_0,
    input wire I_ADDR_STRAP_1,
    input wire I_ADDR_STRAP_2,
    input wire I_WP,
    // received byte stream toward the array
    output reg O_WR_VALID,
    input wire I_WR_READY,
    output reg [7:0] O_WR_DATA,
    output reg O_WR_FIRST,
    // read data from the array
    input wire [7:0] I_RD_DATA,
    input wire I_RD_VALID,
    output reg O_RD_REQ,
    // status
    output reg O_BUSY,
    output reg O_WRITE_START,
    output reg O_OVERRUN
);
    localparam S_IDLE = 6'b000001; // standby, waiting for start
    localparam S_ADDR = 6'b000010; // shifting device address
    localparam S_WRX = 6'b000100; // receiving write bytes
    localparam S_RDX = 6'b001000; // sending read bytes
    localparam S_IGN = 6'b010000; // not addressed, wait for stop/start
    localparam S_WCY = 6'b100000; // internal write cycle
    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for all outside levels
    reg [1:0] scl_s_q, sda_s_q, wp_s_q;
    reg [2:0] strap_a_q, strap_b_q;
    reg scl_q, sda_q; // delayed synced copies for edge detection
    always @(posedge I_CLK) begin
        scl_s_q <= {scl_s_q[0], I_SCL};
        sda_s_q <= {sda_s_q[0], I_SDA};
        wp_s_q <= {wp_s_q[0], I_WP};
        // an open strap arrives as 0 through its pad pull-down [RULE_10]
        strap_a_q <= {I_ADDR_STRAP_2, I_ADDR_STRAP_1, I_ADDR_STRAP_0};
        strap_b_q <= strap_a_q;
        scl_q <= scl_s_q[1];
        sda_q <= sda_s_q[1];
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl && !scl_q; // [RULE_12]
    wire scl_fall = !scl && scl_q; // [RULE_12]
    // sda edges while scl stays high are conditions, never data
    wire start_det = scl && scl_q && sda_q && !sda; // [RULE_01] [RULE_07]
    wire stop_det = scl && scl_q && !sda_q && sda; // [RULE_03] [RULE_07]
    ////////////////////////////////////////////////////////////////////////////
    // protocol state
    reg [5:0] st_q; // one-hot state
    reg [3:0] bit_q; // bit index in frame, 8 = ack slot
    reg [7:0] sh_q; // shift register
    reg ack_q; // ninth-bit decision taken for this byte
    reg first_q; // next written byte is first of transaction
    reg [1:0] wcnt_q; // header bytes seen (word address hi/lo)
    reg got_data_q; // at least one data byte received
    reg prot_q; // write protect latched at start
    reg [31:0] twr_q; // write cycle timer
    reg [7:0] tx_q; // byte being sent
    reg rd_ack_q; // master acknowledge for read continuation
    // fifo in the write path
    wire buf_ready, buf_valid;
    wire [7:0] buf_data;
    reg push_q;
    reg [8:0] push_d_q; // {first,data}
    wire [8:0] buf_out;
    eebf_buf2 #(.WIDTH(9)) u_buf (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_valid(push_q),
        .o_ready(buf_ready),
        .i_data(push_d_q),
        .o_valid(buf_valid),
        // pop exactly when the output stage takes the head, or a word repeats
        .i_ready(!O_WR_VALID || I_WR_READY),
        .o_data(buf_out)
    );
    assign buf_data = buf_out[7:0];
    ////////////////////////////////////////////////////////////////////////////
    // main sequencer: sample on scl rise, drive on scl fall
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            st_q <= S_IDLE;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            first_q <= 1'b0;
            wcnt_q <= 2'd0;
            got_data_q <= 1'b0;
            prot_q <= 1'b0;
            twr_q <= 32'd0;
            tx_q <= ERASED; // [RULE_14]
            rd_ack_q <= 1'b0;
            push_q <= 1'b0;
            push_d_q <= 9'h000;
            O_SDA <= 1'b0;
            O_SDA_OE <= 1'b0;
            O_RD_REQ <= 1'b0;
            O_BUSY <= 1'b0;
            O_WRITE_START <= 1'b0;
            O_OVERRUN <= 1'b0;
        end else begin
            push_q <= 1'b0;
            O_RD_REQ <= 1'b0;
            O_WRITE_START <= 1'b0;
            O_SDA <= 1'b0; // only ever pull low [RULE_11]
            if (I_RD_VALID) begin
                tx_q <= I_RD_DATA;
            end
            if (st_q == S_WCY) begin
                // deaf to the bus until the cycle ends [RULE_18]
                O_SDA_OE <= 1'b0;
                if (twr_q == 32'd0) begin
                    st_q <= S_IDLE;
                    O_BUSY <= 1'b0;
                end else begin
                    twr_q <= twr_q - 32'd1;
                end
            end else if (stop_det) begin
                O_SDA_OE <= 1'b0;
                if (st_q == S_WRX && got_data_q && !prot_q) begin
                    st_q <= S_WCY; // [RULE_05]
                    twr_q <= TWR_CYC - 1;
                    O_BUSY <= 1'b1;
                    O_WRITE_START <= 1'b1;
                end else begin
                    st_q <= S_IDLE; // read abandoned [RULE_04]
                end
            end else if (start_det) begin
                // bus ignored until this point [RULE_02]
                st_q <= S_ADDR;
                bit_q <= 4'd0;
                // a refused address leaves the ack flag set; clear it here
                ack_q <= 1'b0;
                O_SDA_OE <= 1'b0;
                prot_q <= wp_s_q[1]; // [RULE_13]
            end else if (st_q != S_IDLE && st_q != S_IGN) begin
                if (scl_rise && bit_q < 4'd8) begin
                    sh_q <= {sh_q[6:0], sda}; // [RULE_15] [RULE_06]
                    bit_q <= bit_q + 4'd1;
                end else if (scl_rise) begin
                    rd_ack_q <= !sda; // master ack during reads
                end
                if (scl_fall) begin
                    if (bit_q == 4'd8 && !ack_q) begin
                        // end of byte: decide ack for ninth clock [RULE_16]
                        ack_q <= 1'b1;
                        case (st_q)
                            S_ADDR: begin
                                // device code, then strap bits [RULE_08] [RULE_09] [RULE_17]
                                if (sh_q[7:4] == `EEBF_DEV_CODE
                                        && sh_q[3:1] == strap_b_q) begin
                                    O_SDA_OE <= 1'b1;
                                    st_q <= sh_q[0] ? S_RDX : S_WRX;
                                    first_q <= 1'b1;
                                    wcnt_q <= 2'd0;
                                    got_data_q <= 1'b0;
                                    O_RD_REQ <= sh_q[0];
                                end else begin
                                    st_q <= S_IGN;
                                end
                            end
                            S_WRX: begin
                                if (wcnt_q != 2'd2) begin
                                    wcnt_q <= wcnt_q + 2'd1;
                                    O_SDA_OE <= 1'b1;
                                end else begin
                                    got_data_q <= 1'b1;
                                    O_SDA_OE <= !prot_q; // [RULE_19]
                                end
                                if (!prot_q || wcnt_q != 2'd2) begin
                                    // address bytes and unprotected data flow on
                                    push_q <= 1'b1;
                                    push_d_q <= {first_q, sh_q};
                                    O_OVERRUN <= O_OVERRUN | !buf_ready;
                                end
                                first_q <= 1'b0;
                            end
                            default: begin
                                // read: master owns the ack slot
                                O_SDA_OE <= 1'b0;
                            end
                        endcase
                    end else if (bit_q == 4'd8) begin
                        // ninth clock over: release, next byte
                        ack_q <= 1'b0;
                        bit_q <= 4'd0;
                        O_SDA_OE <= 1'b0;
                        if (st_q == S_RDX && (rd_ack_q || first_q)) begin
                            O_SDA_OE <= !tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b1};
                            first_q <= 1'b0;
                        end else if (st_q == S_RDX) begin
                            st_q <= S_IGN; // no ack: master will stop
                        end
                    end else if (st_q == S_RDX && bit_q != 4'd0) begin
                        // shift next read bit out after the fall [RULE_15]
                        if (bit_q == 4'd7) begin
                            O_RD_REQ <= 1'b1; // prefetch next byte
                        end
                        O_SDA_OE <= (bit_q < 4'd8) ? !tx_q[7] : 1'b0;
                        tx_q <= {tx_q[6:0], 1'b1};
                    end
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // output stage of the write stream, registered
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_WR_VALID <= 1'b0;
            O_WR_DATA <= 8'h00;
            O_WR_FIRST <= 1'b0;
        end else if (!O_WR_VALID || I_WR_READY) begin
            O_WR_VALID <= buf_valid;
            O_WR_DATA <= buf_data;
            O_WR_FIRST <= buf_out[8];
        end
    end
endmodule // eebf_top
`default_nettype wire

// File: sim/eebf_asserts.sv
// Purpose: port-level checks of the two-wire front end
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to eebf_top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module eebf_asserts #(
    parameter TWR_CYC = 250000
) (
    input wire logic I_CLK,
    input wire logic I_SRST,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic O_SDA,
    input wire logic O_SDA_OE,
    input wire logic O_WR_VALID,
    input wire logic I_WR_READY,
    input wire logic [7:0] O_WR_DATA,
    input wire logic O_BUSY,
    input wire logic O_WRITE_START
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    // busy length, so a write cycle that never ends is caught
    logic [31:0] busy_n_q;
    always_ff @(posedge I_CLK)
        busy_n_q <= (I_SRST || !O_BUSY) ? 32'h0 : busy_n_q + 32'h1;
    ////////////////////////////////////////
    drive_low_a: assert property (O_SDA_OE |-> !O_SDA)
        else $error("data pin driven high");
    oe_scl_low_a: assert property ($changed(O_SDA_OE) |-> !I_SCL)
        else $error("data drive moved with clock high");
    busy_mute_a: assert property (O_BUSY |-> !O_SDA_OE)
        else $error("acknowledge during write cycle");
    ws_busy_a: assert property (O_WRITE_START |=> O_BUSY)
        else $error("write start without busy");
    ws_stop_a: assert property (O_WRITE_START |-> I_SCL && I_SDA)
        else $error("write start outside a stop");
    ws_pulse_a: assert property (O_WRITE_START |=> !O_WRITE_START [*8])
        else $error("write start not a single pulse");
    stall_hold_a: assert property (
        O_WR_VALID && !I_WR_READY |=> O_WR_VALID && $stable(O_WR_DATA))
        else $error("stalled word lost");
    busy_len_a: assert property (busy_n_q <= TWR_CYC + 2)
        else $error("write cycle too long");
    cover property (O_WRITE_START);
    cover property ($rose(O_SDA_OE));
    cover property (O_WR_VALID && !I_WR_READY);
endmodule // eebf_asserts
bind eebf_top eebf_asserts #(.TWR_CYC(TWR_CYC)) u_chk (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE),
    .O_WR_VALID(O_WR_VALID), .I_WR_READY(I_WR_READY), .O_WR_DATA(O_WR_DATA),
    .O_BUSY(O_BUSY), .O_WRITE_START(O_WRITE_START));
`default_nettype wire

// File: sim/eebf_master.sv
// Purpose: behavioural two-wire bus master
// Assumes: bit time 8 system clocks (160 ns), pull-up on data
// Notes: clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module eebf_master (
    // system clock and device drive enable
    input wire logic clk,
    input wire logic dev_oe,
    // bus wires
    output logic scl,
    output wire logic sda
);
    logic sda_q = 1'b1; // own drive, 1 = released
    initial scl = 1'b1;
    // wired-and: released line is pulled high
    assign sda = sda_q & ~dev_oe;
    ////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves in clock low, read mid clock high
    task automatic bit_x(input logic b, output logic r);
        hold(2);
        sda_q = b;
        hold(3);
        scl = 1'b1;
        hold(2);
        r = sda;
        hold(1);
        scl = 1'b0;
    endtask
    task automatic start();
        hold(2);
        sda_q = 1'b1;
        hold(3);
        scl = 1'b1;
        hold(3);
        sda_q = 1'b0;
        hold(3);
        scl = 1'b0;
    endtask
    task automatic stop();
        hold(2);
        sda_q = 1'b0;
        hold(3);
        scl = 1'b1;
        hold(3);
        sda_q = 1'b1;
        hold(3);
    endtask
    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
        output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(ak, a);
    endtask
endmodule // eebf_master
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench of the two-wire front end
// Assumes: 50 MHz clock, write cycle shortened to 300 cycles
// Notes: sink and read source are modelled here
`timescale 1ns/1ns
`default_nettype none
`include "eebf_defs.vh"
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wp = 1'b0;
    logic wr_ready = 1'b0;
    logic rd_valid = 1'b0;
    logic rd_on = 1'b0; // array model answers read requests
    int ws_cnt = 0; // write cycle starts seen
    logic [2:0] strap = 3'h0; // pull-downs: open straps read 0
    logic [7:0] rd_data = 8'h3C;
    logic [8:0] got[$]; // {first, data}
    wire logic scl, sda, sda_o, sda_oe, wr_valid, wr_first, rd_req, busy, wstart, overrun;
    wire logic [7:0] wr_data;
    int failures = 0;
    int checks = 0;
    always #10 clk = ~clk;
    // sink takes a word on each ready and valid edge
    always @(posedge clk) if (wr_ready && wr_valid) got.push_back({wr_first, wr_data});
    always @(posedge clk) if (wstart === 1'b1) ws_cnt++;
    // array model: one valid pulse per request, driven off the sampling edge
    always @(negedge clk) rd_valid <= rd_on && rd_req;
    eebf_top #(.TWR_CYC(300)) u_dut (.I_CLK(clk), .I_SRST(srst), .I_SCL(scl), .I_SDA(sda),
        .O_SDA(sda_o), .O_SDA_OE(sda_oe), .I_ADDR_STRAP_0(strap[0]),
        .I_ADDR_STRAP_1(strap[1]), .I_ADDR_STRAP_2(strap[2]), .I_WP(wp),
        .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready), .O_WR_DATA(wr_data),
        .O_WR_FIRST(wr_first), .I_RD_DATA(rd_data), .I_RD_VALID(rd_valid),
        .O_RD_REQ(rd_req), .O_BUSY(busy), .O_WRITE_START(wstart), .O_OVERRUN(overrun));
    eebf_master u_mst (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_busy(input logic v);
        int n = 0;
        while (busy !== v) begin
            @(negedge clk);
            n++;
            if (n > 600) begin
                chk(8'h0, 8'h1, "busy wait timeout");
                complete_run();
            end
        end
    endtask
    task automatic addr(input logic [2:0] s, input logic rw, output logic a);
        logic [7:0] q;
        u_mst.start();
        u_mst.xfer({`EEBF_DEV_CODE, s, rw}, 1'b1, q, a);
    endtask
    ////////////////////////////////////////
    // unloaded then loaded read, ended by a stop
    task automatic t_read();
        logic a;
        logic [7:0] q;
        strap = 3'h5;
        for (int k = 0; k < 2; k++) begin
            rd_on = k[0];
            addr(3'h5, 1'b1, a);
            chk({7'h0, a}, 8'h0, "read address ack");
            // ack the unloaded byte so that the stop lands inside the read
            u_mst.xfer(8'hFF, k[0], q, a);
            chk(q, k ? 8'h3C : 8'hFF, "read byte");
            u_mst.stop();
            chk({5'h0, busy, sda_oe, ws_cnt != 0}, 8'h0, "read stop idles");
        end
        $display("test read done");
    endtask
    // every strap setting, matching and mismatching
    task automatic t_straps();
        logic a;
        for (int s = 0; s < 16; s++) begin
            strap = s[2:0];
            addr(s[3] ? ~s[2:0] : s[2:0], 1'b0, a);
            chk({7'h0, a}, {7'h0, s[3]}, "strap match");
            u_mst.stop();
        end
        chk({7'h0, ws_cnt != 0}, 8'h0, "no write cycle without data");
        $display("test straps done");
    endtask
    // stalled sink, stop starts write cycle, polling
    task automatic t_write(input logic p);
        logic a;
        logic [7:0] q;
        logic [7:0] d[4] = '{8'h12, 8'h34, 8'hA5, 8'h5A};
        int w0;
        strap = 3'h2;
        wp = p;
        w0 = ws_cnt;
        got.delete();
        addr(3'h2, 1'b0, a);
        for (int i = 0; i < 4; i++) begin
            if (i == 2 && !p) chk(wr_data, 8'h12, "stalled head word");
            wr_ready = (i >= 2);
            u_mst.xfer(d[i], 1'b1, q, a);
            chk({7'h0, a}, {7'h0, p && i >= 2}, "byte ack");
        end
        u_mst.stop();
        repeat (20) @(negedge clk);
        chk(8'(ws_cnt - w0), {7'h0, !p}, "write cycle start");
        if (p) chk(8'(got.size()), 8'h02, "protected data held back");
        if (!p) begin
            addr(3'h2, 1'b0, a);
            chk({7'h0, a}, 8'h1, "no ack while busy");
            u_mst.stop();
            wait_busy(1'b0);
            for (int i = 0; i < 4; i++) begin
                chk(got[i][7:0], d[i], "word stream");
                chk({7'h0, got[i][8]}, {7'h0, i == 0}, "first word flag");
            end
            chk({7'h0, overrun}, 8'h0, "no overrun");
        end
        wait_busy(1'b0);
        addr(3'h2, 1'b0, a);
        chk({7'h0, a}, 8'h0, "ack after write cycle");
        u_mst.stop();
        wp = 1'b0;
        $display("test write done");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        t_read();
        t_straps();
        t_write(1'b0);
        t_write(1'b1);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
